// file: rtl/apute_consts.svh
`ifndef APUTE_CONSTS_SVH
`define APUTE_CONSTS_SVH

`define APUTE_SR_BIT          7
`define APUTE_OP_MASK         8'h7F
`define APUTE_OP_TANGENT      8'h04
`define APUTE_OP_EXCH32       8'h39
`define APUTE_OP_EXCH16       8'h79
`define APUTE_CYC_TAN_LONG    13'd4894
`define APUTE_CYC_TAN_SHORT   13'd30
`define APUTE_CYC_EXCH32      13'd26
`define APUTE_CYC_EXCH16      13'd18
`define APUTE_EXP_BIAS        8'h7F
`define APUTE_EXP_SMALL       8'h73
`define APUTE_ERR_NONE        4'h0
`define APUTE_ERR_OVERFLOW    4'h8
`define APUTE_CT_THRESH       24'h0000_40

`endif

// file: rtl/apute_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "apute_consts.svh"

module apute_exec
    import apute_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          cmd_valid,
    input  wire logic [7:0]    cmd_byte,
    input  wire apute_stack_t  stack_in,
    output logic               busy,
    output logic               done,
    output logic               service_request,
    output apute_stack_t       stack_out,
    output apute_status_t      status
);

    typedef enum logic [1:0] {
        APUTE_S_IDLE,
        APUTE_S_TAN,
        APUTE_S_WAIT,
        APUTE_S_DONE
    } apute_state_t;

    function automatic apute_op_t decode_op(input logic [7:0] b);
        logic [7:0] low;
        low = b & `APUTE_OP_MASK;
        if (low == `APUTE_OP_TANGENT) begin
            decode_op = APUTE_OP_TAN;
        end else if (low == `APUTE_OP_EXCH32) begin
            decode_op = APUTE_OP_X32;
        end else if (low == `APUTE_OP_EXCH16) begin
            decode_op = APUTE_OP_X16;
        end else begin
            decode_op = APUTE_OP_NONE;
        end
    endfunction

    apute_state_t  state_r;
    apute_op_t     op_r;
    apute_stack_t  stk_r;
    logic [12:0]   cnt_r;
    logic          sr_r;
    logic          tan_start_r;
    logic          tan_done;
    logic [31:0]   tan_res;
    logic          tan_ovf;
    logic [12:0]   tan_cnt_r;
    apute_op_t     dec_op;
    logic          accept;

    always_comb begin
        dec_op = decode_op(cmd_byte);
        accept = cmd_valid && (state_r == APUTE_S_IDLE) && (dec_op != APUTE_OP_NONE);
    end

    apute_tan_core u_tan (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .start    (tan_start_r),
        .arg      (stk_r.top),
        .done     (tan_done),
        .result   (tan_res),
        .overflow (tan_ovf)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= APUTE_S_IDLE;
        end else begin
            case (state_r)
                APUTE_S_IDLE: begin
                    if (accept) begin
                        if (dec_op == APUTE_OP_TAN) begin
                            state_r <= APUTE_S_TAN;
                        end else begin
                            state_r <= APUTE_S_WAIT;
                        end
                    end
                end
                APUTE_S_TAN: begin
                    if (tan_done) begin
                        state_r <= APUTE_S_WAIT;
                    end
                end
                APUTE_S_WAIT: begin
                    if (tan_cnt_r >= cnt_r - 13'h1) begin
                        state_r <= APUTE_S_DONE;
                    end
                end
                APUTE_S_DONE: begin
                    state_r <= APUTE_S_IDLE;
                end
                default: begin
                    state_r <= APUTE_S_IDLE;
                end
            endcase
        end
    end

    // Keeps the kind of the accepted command and its service-request bit.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_r <= APUTE_OP_NONE;
            sr_r <= 1'b0;
        end else if (accept) begin
            op_r <= dec_op;
            sr_r <= cmd_byte[`APUTE_SR_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tan_start_r <= 1'b0;
        end else begin
            tan_start_r <= accept && (dec_op == APUTE_OP_TAN);
        end
    end

    // Sets the total execution time of the accepted command.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 13'h0;
        end else if (accept) begin
            if (dec_op == APUTE_OP_TAN) begin
                cnt_r <= (stack_in.top[30:23] < `APUTE_EXP_SMALL) ?
                         `APUTE_CYC_TAN_SHORT : `APUTE_CYC_TAN_LONG;
            end else if (dec_op == APUTE_OP_X16) begin
                cnt_r <= `APUTE_CYC_EXCH16;
            end else begin
                cnt_r <= `APUTE_CYC_EXCH32;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tan_cnt_r <= 13'h0;
        end else if (accept) begin
            tan_cnt_r <= 13'h1;
        end else if (state_r == APUTE_S_TAN || state_r == APUTE_S_WAIT) begin
            tan_cnt_r <= tan_cnt_r + 13'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stk_r <= '0;
        end else if (accept) begin
            stk_r <= stack_in;
        end else if (state_r == APUTE_S_TAN && tan_done) begin
            stk_r.top <= tan_res;
            stk_r.third <= 32'h0;
            stk_r.fourth <= 32'h0;
        end else if (state_r == APUTE_S_WAIT && tan_cnt_r == 13'h1) begin
            if (op_r == APUTE_OP_X32) begin
                stk_r.top <= stk_r.next;
                stk_r.next <= stk_r.top;
            end else if (op_r == APUTE_OP_X16) begin
                stk_r.top <= {stk_r.top[31:16], stk_r.next[15:0]};
                stk_r.next <= {stk_r.next[31:16], stk_r.top[15:0]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r != APUTE_S_IDLE) || accept;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
        end else begin
            done <= (state_r == APUTE_S_DONE);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            service_request <= 1'b0;
        end else if (state_r == APUTE_S_DONE) begin
            service_request <= sr_r;
        end else if (accept) begin
            service_request <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stack_out <= '0;
        end else if (state_r == APUTE_S_DONE) begin
            stack_out <= stk_r;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status <= '0;
        end else if (state_r == APUTE_S_DONE) begin
            if (op_r == APUTE_OP_X16) begin
                status.sign <= stk_r.top[15];
                status.zero <= (stk_r.top[15:0] == 16'h0);
            end else begin
                status.sign <= stk_r.top[31];
                status.zero <= (stk_r.top[30:0] == 31'h0);
            end
            if (op_r == APUTE_OP_TAN) begin
                status.err <= tan_ovf ? `APUTE_ERR_OVERFLOW : `APUTE_ERR_NONE;
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/apute_pkg.sv
package apute_pkg;

    typedef enum logic [1:0] {
        APUTE_OP_NONE,
        APUTE_OP_TAN,
        APUTE_OP_X32,
        APUTE_OP_X16
    } apute_op_t;

    typedef struct packed {
        logic       sign;
        logic       zero;
        logic [3:0] err;
    } apute_status_t;

    typedef struct packed {
        logic [31:0] top;
        logic [31:0] next;
        logic [31:0] third;
        logic [31:0] fourth;
    } apute_stack_t;

endpackage

// file: rtl/apute_tan_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "apute_consts.svh"

module apute_tan_core
    import apute_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        start,
    input  wire logic [31:0] arg,
    output logic             done,
    output logic [31:0]      result,
    output logic             overflow
);
    // Evaluates the tangent by shift-and-add rotation of a fixed-point angle.
    logic [31:0] x_r, y_r, z_r;
    logic [4:0]  it_r;
    logic        busy_r;
    logic        neg_r;
    logic        small_r;
    logic [31:0] atan_lut [0:23];

    initial begin
        for (int i = 0; i < 24; i++) begin
            atan_lut[i] = 32'(longint'($atan(2.0 ** (-i)) * (2.0 ** 28)));
        end
    end

    function automatic logic [31:0] to_fixed(input logic [31:0] f);
        logic [7:0]  e;
        logic [31:0] m;
        e = f[30:23];
        m = {3'h0, 1'b1, f[22:0], 5'h0};
        if (e > 8'd130) begin
            to_fixed = 32'h7FFF_FFFF;
        end else if (e >= 8'd127) begin
            to_fixed = m << (e - 8'd127);
        end else begin
            to_fixed = m >> (8'd127 - e);
        end
    endfunction

    logic [31:0] fx_arg;
    logic [31:0] quarter;
    logic [31:0] red;
    logic        fold;
    always_comb begin
        fx_arg  = to_fixed(arg);
        quarter = 32'h0C90_FDAA;
        fold    = 1'b0;
        red     = fx_arg % (quarter << 1);
        if (red > quarter) begin
            red  = (quarter << 1) - red;
            fold = 1'b1;
        end
    end

    logic fold_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            x_r <= 32'h0;
            y_r <= 32'h0;
            z_r <= 32'h0;
            it_r <= 5'h0;
            busy_r <= 1'b0;
            neg_r <= 1'b0;
            small_r <= 1'b0;
            fold_r <= 1'b0;
            done <= 1'b0;
            result <= 32'h0;
            overflow <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                x_r <= 32'h09B7_4EDA;
                y_r <= 32'h0;
                z_r <= red;
                it_r <= 5'h0;
                busy_r <= 1'b1;
                neg_r <= arg[31];
                fold_r <= fold;
                small_r <= (arg[30:23] < `APUTE_EXP_SMALL);
            end else if (busy_r) begin
                if (it_r == 5'd23) begin
                    busy_r <= 1'b0;
                    done <= 1'b1;
                    if (small_r) begin
                        result <= arg;
                        overflow <= 1'b0;
                    end else begin
                        result <= fixed_ratio(fold_r ? x_r : y_r, fold_r ? y_r : x_r, neg_r);
                        overflow <= fold_r && (y_r[31:12] == 20'h0);
                    end
                end else begin
                    it_r <= it_r + 5'd1;
                    if (!z_r[31]) begin
                        x_r <= x_r - (y_r >>> it_r);
                        y_r <= y_r + (x_r >>> it_r);
                        z_r <= z_r - atan_lut[it_r];
                    end else begin
                        x_r <= x_r + (y_r >>> it_r);
                        y_r <= y_r - (x_r >>> it_r);
                        z_r <= z_r + atan_lut[it_r];
                    end
                end
            end
        end
    end

    function automatic logic [31:0] fixed_ratio(input logic [31:0] n, input logic [31:0] d, input logic s);
        logic [55:0] q;
        logic [7:0]  e;
        q = (d == 32'h0) ? 56'h0 : ({n, 24'h0} / {24'h0, d});
        e = 8'd150;
        for (int k = 0; k < 32; k++) begin
            if (q[55:24] != 32'h0) begin
                q = q >> 1;
                e = e + 8'd1;
            end
        end
        for (int k = 0; k < 24; k++) begin
            if (q != 56'h0 && !q[23]) begin
                q = q << 1;
                e = e - 8'd1;
            end
        end
        fixed_ratio = (q == 56'h0) ? {s, 31'h0} : {s, e - 8'd24, q[22:0]};
    endfunction

endmodule
`default_nettype wire

// file: verification/apute_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none

module apute_exec_properties
    import apute_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          cmd_valid,
    input  wire logic [7:0]    cmd_byte,
    input  wire apute_stack_t  stack_in,
    input  wire logic          busy,
    input  wire logic          done,
    input  wire logic          service_request,
    input  wire apute_stack_t  stack_out,
    input  wire apute_status_t status
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic         tan, x32, x16, take, sr_r, long_r;
    logic [6:0]   op_r;
    logic [12:0]  cnt_r;
    apute_stack_t stk_r;
    assign tan  = cmd_byte[6:0] == 7'h04;
    assign x32  = cmd_byte[6:0] == 7'h39;
    assign x16  = cmd_byte[6:0] == 7'h79;
    assign take = cmd_valid && !busy && (tan || x32 || x16);

    // Captures the accepted command and counts cycles since it was taken.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_r   <= 7'h00;
            sr_r   <= 1'b0;
            long_r <= 1'b0;
            stk_r  <= '0;
            cnt_r  <= 13'h0000;
        end else if (take) begin
            op_r   <= cmd_byte[6:0];
            sr_r   <= cmd_byte[7];
            long_r <= stack_in.top[30:23] >= 8'h73;
            stk_r  <= stack_in;
            cnt_r  <= 13'h0000;
        end else if (cnt_r != 13'h1FFF) begin
            cnt_r <= cnt_r + 13'h0001;
        end
    end

    sequence s_x32; take && x32; endsequence
    sequence s_x16; take && x16; endsequence
    sequence s_tiny; take && tan && stack_in.top[30:23] < 8'h73; endsequence

    a_x32_timing: assert property (s_x32 |=> !done [*8] ##[15:19] done) else $error("exchange32 timing");
    a_x16_timing: assert property (s_x16 |=> !done [*8] ##[7:11] done) else $error("exchange16 timing");
    a_tiny_timing: assert property (s_tiny |=> !done [*8] ##[19:31] done) else $error("tiny tangent timing");
    a_long_min: assert property (done && op_r == 7'h04 && long_r |-> cnt_r >= 13'd4892) else $error("tangent early");
    a_x32_swap: assert property (done && op_r == 7'h39 |-> stack_out.top == stk_r.next
        && stack_out.next == stk_r.top && stack_out.third == stk_r.third) else $error("exchange32 data");
    a_x16_swap: assert property (done && op_r == 7'h79 |-> stack_out.top[15:0] == stk_r.next[15:0]
        && stack_out.next[15:0] == stk_r.top[15:0]) else $error("exchange16 data");
    a_tan_keep: assert property (done && op_r == 7'h04 |-> stack_out.next == stk_r.next) else $error("second lost");
    a_tiny_ident: assert property (done && op_r == 7'h04 && !long_r |-> stack_out.top == stk_r.top)
        else $error("tiny tangent not identity");
    a_x16_flags: assert property (done && op_r == 7'h79 |-> status.sign == stack_out.top[15]
        && status.zero == (stack_out.top[15:0] == 16'h0000)) else $error("exchange16 flags");
    a_sign_follow: assert property (done && op_r != 7'h79 |-> status.sign == stack_out.top[31]) else $error("sign");
    a_err_kept: assert property (done && op_r != 7'h04 |-> $stable(status.err)) else $error("error field moved");
    a_refuse_bad: assert property (cmd_valid && !busy && !(tan || x32 || x16) |=> !busy) else $error("bad byte taken");
    a_sr_follow: assert property ($rose(done) |-> ##[0:1] service_request == sr_r) else $error("service request");
endmodule

bind apute_exec apute_exec_properties chk (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .stack_in(stack_in), .busy(busy), .done(done), .service_request(service_request),
    .stack_out(stack_out), .status(status));

`default_nettype wire

// file: verification/apute_host.sv
`timescale 1ns/1ps
`default_nettype none

module apute_host
    import apute_pkg::*;
(
    input  wire logic   sys_clk,
    output logic        cmd_valid,
    output logic [7:0]  cmd_byte,
    output apute_stack_t stack_in
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        stack_in  = '0;
    end

    // Presents one command for one edge, then scrambles the bus so stale data is never reused.
    task automatic issue(input logic [7:0] b, input apute_stack_t s);
        @(negedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_byte  <= b;
        stack_in  <= s;
        @(negedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~b;
        stack_in  <= ~s;
    endtask
endmodule

`default_nettype wire

// file: verification/apute_tangent_and_stack_exchange_test.sv
`timescale 1ns/1ps
`default_nettype none

module apute_tangent_and_stack_exchange_test
    import apute_pkg::*;
;
    logic          sys_clk, arst_n, cmd_valid, busy, done, service_request;
    logic [7:0]    cmd_byte;
    apute_stack_t  stack_in, stack_out, s;
    apute_status_t status;
    int            failures, checked, n;
    logic [3:0]    err0;

    apute_host host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .stack_in(stack_in));
    apute_exec uut (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .stack_in(stack_in), .busy(busy), .done(done), .service_request(service_request),
        .stack_out(stack_out), .status(status));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Issues one command and counts edges until completion, giving up after a bound.
    task automatic run(input logic [7:0] b);
        repeat (2) @(negedge sys_clk);
        err0 = status.err;
        host.issue(b, s);
        n = 0;
        while (done !== 1'b1 && n < 7000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 7000) begin
            failures++;
            tally_and_finish();
        end
    endtask

    task automatic s_exchange32();
        for (int i = 0; i < 2; i++) begin
            s = '{32'h3F80_0000, 32'hC040_0000, 32'h1234_5678, 32'h9ABC_DEF0};
            run(i == 0 ? 8'h39 : 8'hB9);
            check({31'd0, n >= 25 && n <= 27}, 32'd1);
            check(stack_out.top, s.next);
            check(stack_out.next, s.top);
            check(stack_out.fourth, s.fourth);
            check({31'd0, status.sign}, 32'd1);
            check({28'd0, status.err}, {28'd0, err0});
            check({31'd0, service_request}, i);
        end
    endtask

    task automatic s_exchange16();
        for (int i = 0; i < 2; i++) begin
            s = '{32'h0000_8001, 32'h0000_0000, 32'h0000_0003, 32'h0000_0004};
            run(i == 0 ? 8'h79 : 8'hF9);
            check({31'd0, n >= 17 && n <= 19}, 32'd1);
            check({16'd0, stack_out.next[15:0]}, 32'h0000_8001);
            check({30'd0, status.sign, status.zero}, 32'd1);
            check({28'd0, status.err}, {28'd0, err0});
            check({31'd0, service_request}, i);
        end
    endtask

    task automatic s_tangent();
        s = '{32'h3800_1234, 32'h4120_0000, 32'h0000_0001, 32'h0000_0002};
        run(8'h04);
        check({31'd0, n >= 29 && n <= 40}, 32'd1);
        check(stack_out.top, s.top);
        check(stack_out.next, s.next);
        check({31'd0, service_request}, 32'd0);
        s = '{32'h3F80_0000, 32'h4120_0000, 32'h0000_0001, 32'h0000_0002};
        run(8'h84);
        check({31'd0, n >= 4893 && n <= 6000}, 32'd1);
        check(stack_out.next, s.next);
        check({26'd0, status}, 32'd0);
        check({31'd0, service_request}, 32'd1);
    endtask

    task automatic s_refused();
        host.issue(8'h02, s);
        repeat (40) @(posedge sys_clk);
        #1;
        check({30'd0, busy, done}, 32'd0);
    endtask

    initial begin
        failures = 0;
        checked  = 0;
        arst_n   = 1'b0;
        s        = '0;
        repeat (10) @(negedge sys_clk);
        arst_n = 1'b1;
        s_exchange32();
        s_exchange16();
        s_tangent();
        s_refused();
        tally_and_finish();
    end
endmodule

`default_nettype wire
